// ### logic/stm_pkg.sv
package stm_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_ALARM_FLAGS_FIRST  = 8'h00;
   localparam logic [7:0] ADDR_SHARED_LOW_BITS    = 8'h03;
   localparam logic [7:0] ADDR_REMOTE_LOW_BITS    = 8'h04;
   localparam logic [7:0] ADDR_SUPPLY_HIGH_BITS   = 8'h06;
   localparam logic [7:0] ADDR_ONCHIP_HIGH_BITS   = 8'h07;
   localparam logic [7:0] ADDR_REMOTE_HIGH_BITS   = 8'h08;
   localparam logic [7:0] ADDR_SECOND_ALARM_FLAGS = 8'h10;
   localparam logic [7:0] ADDR_FIRST_CONTROL      = 8'h18;
   localparam logic [7:0] ADDR_SECOND_CONTROL     = 8'h19;
   localparam logic [7:0] ADDR_ALARM_MASK_FIRST   = 8'h1d;
   localparam logic [7:0] ADDR_ALARM_MASK_SECOND  = 8'h1e;
   localparam logic [7:0] ADDR_ONCHIP_OFFSET      = 8'h1f;
   localparam logic [7:0] ADDR_REMOTE_OFFSET      = 8'h20;
   localparam logic [7:0] ADDR_SUPPLY_UPPER       = 8'h23;
   localparam logic [7:0] ADDR_SUPPLY_LOWER       = 8'h24;
   localparam logic [7:0] ADDR_ONCHIP_UPPER       = 8'h25;
   localparam logic [7:0] ADDR_ONCHIP_LOWER       = 8'h26;
   localparam logic [7:0] ADDR_REMOTE_UPPER       = 8'h27;
   localparam logic [7:0] ADDR_REMOTE_LOWER       = 8'h28;

   // ==========================================================
   // Field positions
   localparam int MONITOR_ENABLE_BIT   = 0;
   localparam int ALERT_ACTIVE_HIGH_BIT = 6;
   localparam int SINGLE_CHANNEL_BIT   = 4;
   localparam int AVERAGING_OFF_BIT    = 5;
   localparam int FLAG_ONCHIP_HIGH     = 0;
   localparam int FLAG_ONCHIP_LOW      = 1;
   localparam int FLAG_REMOTE_HIGH     = 2;
   localparam int FLAG_REMOTE_LOW      = 3;
   localparam int FLAG_SUPPLY          = 0;

   // ==========================================================
   // Channels and counts
   localparam logic [1:0] CH_SUPPLY = 2'h0;
   localparam logic [1:0] CH_ONCHIP = 2'h1;
   localparam logic [1:0] CH_REMOTE = 2'h2;
   localparam logic [3:0] AVG_LAST  = 4'hf;

   // ==========================================================
   // Reset values
   localparam logic [7:0] SUPPLY_UPPER_RESET = 8'hc7;
   localparam logic [7:0] SUPPLY_LOWER_RESET = 8'h62;
   localparam logic [7:0] ONCHIP_UPPER_RESET = 8'h64;
   localparam logic [7:0] ONCHIP_LOWER_RESET = 8'hc9;
   localparam logic [7:0] REMOTE_UPPER_RESET = 8'h64;
   localparam logic [7:0] REMOTE_LOWER_RESET = 8'hc9;

   typedef enum logic [1:0] {
      STM_IDLE  = 2'b00,
      STM_START = 2'b01,
      STM_WAIT  = 2'b10
   } stm_seq_e;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       txn_active;
   } stm_reg_req_s;

   typedef struct packed {
      logic       done;
      logic [9:0] code;
   } stm_adc_rsp_s;

   typedef struct packed {
      stm_seq_e   seq;
      logic [1:0] chan;
      logic [3:0] cnt;
      logic [13:0] acc;
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] mask1;
      logic [7:0] mask2;
      logic [7:0] onchip_offset;
      logic [7:0] remote_offset;
      logic [7:0] supply_upper_limit;
      logic [7:0] supply_lower_limit;
      logic [7:0] onchip_upper;
      logic [7:0] onchip_lower;
      logic [7:0] remote_upper;
      logic [7:0] remote_lower;
      logic [9:0] res_supply;
      logic [9:0] res_onchip;
      logic [9:0] res_remote;
      logic [7:0] view_supply;
      logic [7:0] view_onchip;
      logic [7:0] view_remote;
      logic       lock_shared;
      logic       lock_remote;
      logic [7:0] flags1;
      logic [7:0] flags2;
      logic [7:0] rdata;
      logic       conv_start;
      logic [1:0] conv_chan;
      logic       ref_on;
      logic       alert;
   } stm_state_s;

   localparam stm_state_s STM_RESET_STATE = '{
      seq:                STM_IDLE,
      supply_upper_limit: SUPPLY_UPPER_RESET,
      supply_lower_limit: SUPPLY_LOWER_RESET,
      onchip_upper:       ONCHIP_UPPER_RESET,
      onchip_lower:       ONCHIP_LOWER_RESET,
      remote_upper:       REMOTE_UPPER_RESET,
      remote_lower:       REMOTE_LOWER_RESET,
      default:            '0
   };

endpackage

// ### logic/stm_sequencer.sv
// What this block does
// [R1] Supply pin is digitised as unsigned 10-bit code, first channel.
// [R2] Supply low two bits in shared low register, high eight in own register.
// [R3] Supply result checked against upper/lower limits; unmasked miss sets flag.
// [R4] Any unmasked out-of-limit flag drives alert to configured active level.
// [R5] Host sets single-channel bit and clears selects to watch supply only.
// [R6] Supply always uses internal reference; full-scale code means 7 V.
// [R7] After reset: round-robin, monitoring off, no conversions.
// [R8] Writing monitor-enable one in first control starts conversions.
// [R9] Round-robin order supply, on-chip, remote, then repeat forever.
// [R10] Bit 4 of second control selects single-channel mode.
// [R11] Select 00 picks supply, only lowest bit set (01) picks on-chip sensor.
// [R12] Single-channel conversions follow each other with no idle gap.
// [R13] Serial transaction halts conversion; resumes when it completes.
// [R14] On-chip offset is added before storing; result is two's complement.
// [R15] Remote result is the average of sixteen measurements.
// [R16] Temperatures are 10-bit two's complement, quarter degree per count.
// [R17] Stored temperatures are compared against their high and low limits.
// [R18] Reference amplifier powered only while monitoring is enabled.
// [R19] Low-bits read first freezes its high-bits registers until one is read.
// [R20] Averaging on after reset; bit 5 of second control disables it.
// [R21] Select with only second bit set picks remote; other codes reserved.
module stm_sequencer (
   input  wire logic                  mclk,
   input  wire logic                  arst_n,
   input  wire stm_pkg::stm_reg_req_s reg_req,
   output logic      [7:0]            reg_rdata,
   input  wire stm_pkg::stm_adc_rsp_s adc_rsp,
   output logic                       conv_start,
   output logic      [1:0]            conv_chan,
   output logic                       ref_amp_on,
   output logic                       alert
);

   // ==========================================================
   // State
   stm_pkg::stm_state_s st;
   stm_pkg::stm_state_s next_st;

   logic        mon_en;
   logic        single;
   logic        avg_on;
   logic [1:0]  sel_chan;
   logic        is_temp;
   logic        last_sample;
   logic [13:0] code_ext;
   logic [13:0] sum;
   logic [9:0]  avg;
   logic [9:0]  offset_ext;
   logic [9:0]  value;
   logic [1:0]  after_chan;
   logic        pending;

   always_comb begin
      mon_en   = st.ctrl1[stm_pkg::MONITOR_ENABLE_BIT];
      single   = st.ctrl2[stm_pkg::SINGLE_CHANNEL_BIT];
      avg_on   = ~st.ctrl2[stm_pkg::AVERAGING_OFF_BIT];           // see [R20]
      // Reserved select code 11 falls back to the supply channel
      case (st.ctrl2[1:0])
         2'b01: sel_chan = stm_pkg::CH_ONCHIP;                     // see [R11]
         2'b10: sel_chan = stm_pkg::CH_REMOTE;                     // see [R21]
         default: sel_chan = stm_pkg::CH_SUPPLY;                   // see [R11]
      endcase
      is_temp     = (st.chan != stm_pkg::CH_SUPPLY);
      last_sample = !(is_temp && avg_on) || (st.cnt == stm_pkg::AVG_LAST); // see [R15]
      // Supply code is unsigned, temperature codes signed
      code_ext = is_temp ? {{4{adc_rsp.code[9]}}, adc_rsp.code}
                         : {4'h0, adc_rsp.code};                   // see [R1] [R16]
      sum      = 14'(st.acc + code_ext);
      avg      = (is_temp && avg_on) ? sum[13:4] : adc_rsp.code;  // see [R15]
      offset_ext = (st.chan == stm_pkg::CH_ONCHIP)
                   ? {{2{st.onchip_offset[7]}}, st.onchip_offset}
                   : {{2{st.remote_offset[7]}}, st.remote_offset};
      value    = is_temp ? 10'(avg + offset_ext) : avg;           // see [R14]
      if (single) begin
         after_chan = sel_chan;                                    // see [R12]
      end else begin
         case (st.chan)
            stm_pkg::CH_SUPPLY: after_chan = stm_pkg::CH_ONCHIP;   // see [R9]
            stm_pkg::CH_ONCHIP: after_chan = stm_pkg::CH_REMOTE;   // see [R9]
            default:            after_chan = stm_pkg::CH_SUPPLY;   // see [R9]
         endcase
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_st            = st;
      next_st.conv_start = 1'b0;
      pending            = 1'b0;

      // Register reads: data mux and read side effects
      if (reg_req.rd) begin
         case (reg_req.addr)
            stm_pkg::ADDR_ALARM_FLAGS_FIRST: begin
               next_st.rdata  = st.flags1;
               next_st.flags1 = 8'h00;
            end
            stm_pkg::ADDR_SECOND_ALARM_FLAGS: begin
               next_st.rdata  = st.flags2;
               next_st.flags2 = 8'h00;
            end
            stm_pkg::ADDR_SHARED_LOW_BITS: begin
               next_st.rdata = {4'h0, st.res_onchip[1:0], st.res_supply[1:0]}; // see [R2]
               next_st.lock_shared = 1'b1;                         // see [R19]
            end
            stm_pkg::ADDR_REMOTE_LOW_BITS: begin
               next_st.rdata       = {6'h00, st.res_remote[1:0]};
               next_st.lock_remote = 1'b1;                         // see [R19]
            end
            stm_pkg::ADDR_SUPPLY_HIGH_BITS: begin
               next_st.rdata       = st.view_supply;               // see [R2]
               next_st.lock_shared = 1'b0;                         // see [R19]
               next_st.lock_remote = 1'b0;
            end
            stm_pkg::ADDR_ONCHIP_HIGH_BITS: begin
               next_st.rdata       = st.view_onchip;
               next_st.lock_shared = 1'b0;                         // see [R19]
               next_st.lock_remote = 1'b0;
            end
            stm_pkg::ADDR_REMOTE_HIGH_BITS: begin
               next_st.rdata       = st.view_remote;
               next_st.lock_shared = 1'b0;                         // see [R19]
               next_st.lock_remote = 1'b0;
            end
            stm_pkg::ADDR_FIRST_CONTROL:     next_st.rdata = st.ctrl1;
            stm_pkg::ADDR_SECOND_CONTROL:    next_st.rdata = st.ctrl2;
            stm_pkg::ADDR_ALARM_MASK_FIRST:  next_st.rdata = st.mask1;
            stm_pkg::ADDR_ALARM_MASK_SECOND: next_st.rdata = st.mask2;
            stm_pkg::ADDR_ONCHIP_OFFSET:     next_st.rdata = st.onchip_offset;
            stm_pkg::ADDR_REMOTE_OFFSET:     next_st.rdata = st.remote_offset;
            stm_pkg::ADDR_SUPPLY_UPPER:      next_st.rdata = st.supply_upper_limit;
            stm_pkg::ADDR_SUPPLY_LOWER:      next_st.rdata = st.supply_lower_limit;
            stm_pkg::ADDR_ONCHIP_UPPER:      next_st.rdata = st.onchip_upper;
            stm_pkg::ADDR_ONCHIP_LOWER:      next_st.rdata = st.onchip_lower;
            stm_pkg::ADDR_REMOTE_UPPER:      next_st.rdata = st.remote_upper;
            stm_pkg::ADDR_REMOTE_LOWER:      next_st.rdata = st.remote_lower;
            default:                         next_st.rdata = 8'h00;
         endcase
      end

      // Register writes
      if (reg_req.wr) begin
         case (reg_req.addr)
            stm_pkg::ADDR_FIRST_CONTROL:     next_st.ctrl1 = reg_req.wdata;     // see [R8]
            stm_pkg::ADDR_SECOND_CONTROL:    next_st.ctrl2 = reg_req.wdata;     // see [R10]
            stm_pkg::ADDR_ALARM_MASK_FIRST:  next_st.mask1 = reg_req.wdata;
            stm_pkg::ADDR_ALARM_MASK_SECOND: next_st.mask2 = reg_req.wdata;
            stm_pkg::ADDR_ONCHIP_OFFSET:     next_st.onchip_offset = reg_req.wdata;
            stm_pkg::ADDR_REMOTE_OFFSET:     next_st.remote_offset = reg_req.wdata;
            stm_pkg::ADDR_SUPPLY_UPPER:      next_st.supply_upper_limit = reg_req.wdata;
            stm_pkg::ADDR_SUPPLY_LOWER:      next_st.supply_lower_limit = reg_req.wdata;
            stm_pkg::ADDR_ONCHIP_UPPER:      next_st.onchip_upper = reg_req.wdata;
            stm_pkg::ADDR_ONCHIP_LOWER:      next_st.onchip_lower = reg_req.wdata;
            stm_pkg::ADDR_REMOTE_UPPER:      next_st.remote_upper = reg_req.wdata;
            stm_pkg::ADDR_REMOTE_LOWER:      next_st.remote_lower = reg_req.wdata;
            default: ;
         endcase
      end

      // ==========================================================
      // Conversion sequencer
      case (st.seq)
         stm_pkg::STM_IDLE: begin
            if (mon_en && !reg_req.txn_active) begin              // see [R7] [R8]
               next_st.chan = single ? sel_chan : stm_pkg::CH_SUPPLY;
               next_st.cnt  = 4'h0;
               next_st.acc  = 14'h0000;
               next_st.seq  = stm_pkg::STM_START;
            end
         end
         stm_pkg::STM_START: begin
            // Same reference for every channel, so the channel code is all the front end needs
            next_st.conv_start = 1'b1;                             // see [R6]
            next_st.conv_chan  = st.chan;
            next_st.seq        = stm_pkg::STM_WAIT;
         end
         stm_pkg::STM_WAIT: begin
            if (adc_rsp.done) begin
               next_st.seq = stm_pkg::STM_START;                   // see [R12]
               if (last_sample) begin
                  next_st.cnt  = 4'h0;
                  next_st.acc  = 14'h0000;
                  next_st.chan = after_chan;
                  case (st.chan)
                     stm_pkg::CH_SUPPLY: begin
                        next_st.res_supply = value;                // see [R1]
                        // A masked supply miss leaves no flag, so unmasking later stays quiet
                        if ((value[9:2] > st.supply_upper_limit ||
                             value[9:2] <= st.supply_lower_limit) &&
                            !st.mask2[stm_pkg::FLAG_SUPPLY]) begin
                           next_st.flags2[stm_pkg::FLAG_SUPPLY] = 1'b1; // see [R3]
                        end
                     end
                     stm_pkg::CH_ONCHIP: begin
                        next_st.res_onchip = value;                // see [R14]
                        next_st.flags1[stm_pkg::FLAG_ONCHIP_HIGH] = next_st.flags1[0] |
                           ($signed(value[9:2]) > $signed(st.onchip_upper));   // see [R17]
                        next_st.flags1[stm_pkg::FLAG_ONCHIP_LOW] = next_st.flags1[1] |
                           ($signed(value[9:2]) <= $signed(st.onchip_lower));  // see [R17]
                     end
                     default: begin
                        next_st.res_remote = value;                // see [R15]
                        next_st.flags1[stm_pkg::FLAG_REMOTE_HIGH] = next_st.flags1[2] |
                           ($signed(value[9:2]) > $signed(st.remote_upper));   // see [R17]
                        next_st.flags1[stm_pkg::FLAG_REMOTE_LOW] = next_st.flags1[3] |
                           ($signed(value[9:2]) <= $signed(st.remote_lower));  // see [R17]
                     end
                  endcase
               end else begin
                  next_st.cnt = 4'(st.cnt + 4'h1);
                  next_st.acc = sum;
               end
            end
         end
         default: next_st.seq = stm_pkg::STM_IDLE;
      endcase

      // A transaction or disable discards the partial average and restarts cleanly
      if (reg_req.txn_active || !mon_en) begin
         next_st.seq = stm_pkg::STM_IDLE;                          // see [R13]
         next_st.conv_start = 1'b0;
      end

      // Frozen high-bit views keep the pair consistent for the host
      if (!next_st.lock_shared) begin
         next_st.view_supply = next_st.res_supply[9:2];            // see [R19]
         next_st.view_onchip = next_st.res_onchip[9:2];
      end
      if (!next_st.lock_remote) begin
         next_st.view_remote = next_st.res_remote[9:2];            // see [R19]
      end

      next_st.ref_on = next_st.ctrl1[stm_pkg::MONITOR_ENABLE_BIT]; // see [R18]
      pending = |(next_st.flags1[3:0] & ~next_st.mask1[3:0]) |
                (next_st.flags2[stm_pkg::FLAG_SUPPLY] & ~next_st.mask2[stm_pkg::FLAG_SUPPLY]);
      next_st.alert = pending ~^ next_st.ctrl1[stm_pkg::ALERT_ACTIVE_HIGH_BIT]; // see [R4]
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st <= stm_pkg::STM_RESET_STATE;                           // see [R7] [R20]
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata  = st.rdata;
   assign conv_start = st.conv_start;
   assign conv_chan  = st.conv_chan;
   assign ref_amp_on = st.ref_on;
   assign alert      = st.alert;

endmodule

// ### sim/stm_sequencer_assertions.sv
module stm_sequencer_assertions (
   input wire logic                  mclk,
   input wire logic                  arst_n,
   input wire stm_pkg::stm_reg_req_s reg_req,
   input wire logic [7:0]            reg_rdata,
   input wire stm_pkg::stm_adc_rsp_s adc_rsp,
   input wire logic                  conv_start,
   input wire logic [1:0]            conv_chan,
   input wire logic                  ref_amp_on,
   input wire logic                  alert
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctl1_q;
   logic [7:0] ctl2_q;
   // Shadows built from host writes only, never from what the design reports
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctl1_q <= 8'h00;
         ctl2_q <= 8'h00;
      end else if (reg_req.wr) begin
         if (reg_req.addr == stm_pkg::ADDR_FIRST_CONTROL) ctl1_q <= reg_req.wdata;
         if (reg_req.addr == stm_pkg::ADDR_SECOND_CONTROL) ctl2_q <= reg_req.wdata;
      end
   end
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   // ==========================================================
   // Properties
   property p_ref;
      ref_amp_on == ctl1_q[0];
   endproperty
   a_ref: assert property (p_ref) else $error("reference power off track");
   // Enable edge, then IDLE to START, then the registered start pulse
   property p_start;
      (reg_req.wr && reg_req.addr == stm_pkg::ADDR_FIRST_CONTROL && reg_req.wdata[0]
       && !ref_amp_on && !reg_req.txn_active)
         ##1 (!reg_req.txn_active && ref_amp_on) [*2] |=> conv_start;
   endproperty
   a_start: assert property (p_start) else $error("no start after enable");
   property p_halt;
      reg_req.txn_active [*3] |-> !conv_start;
   endproperty
   a_halt: assert property (p_halt) else $error("start during transfer");
   // Supply, single channel and round robin all chain the next start two cycles on
   property p_next;
      (adc_rsp.done && ref_amp_on && !reg_req.txn_active)
         ##1 (ref_amp_on && !reg_req.txn_active && !reg_req.wr) |=> conv_start;
   endproperty
   a_next: assert property (p_next) else $error("gap after conversion");
   property p_quiet;
      !ref_amp_on [*3] |-> !conv_start;
   endproperty
   a_quiet: assert property (p_quiet) else $error("start while disabled");
   property p_single;
      conv_start && ctl2_q[4] && ctl2_q == $past(ctl2_q, 2)
         |-> conv_chan == ((ctl2_q[1:0] == 2'h3) ? stm_pkg::CH_SUPPLY : ctl2_q[1:0]);
   endproperty
   a_single: assert property (p_single) else $error("wrong single channel");
   property p_ctl2;
      reg_req.rd && !reg_req.wr && reg_req.addr == stm_pkg::ADDR_SECOND_CONTROL
         |=> reg_rdata == ctl2_q;
   endproperty
   a_ctl2: assert property (p_ctl2) else $error("control readback wrong");
   property p_lowpack;
      reg_req.rd && reg_req.addr == stm_pkg::ADDR_SHARED_LOW_BITS |=> reg_rdata[7:4] == 4'h0;
   endproperty
   a_lowpack: assert property (p_lowpack) else $error("low bits packing");
   c_remote: cover property (conv_start && conv_chan == stm_pkg::CH_REMOTE);
   c_alert_high: cover property (alert && ctl1_q[6]);
   c_halt: cover property (reg_req.txn_active [*3]);
endmodule

// ### sim/stm_adc_model.sv
module stm_adc_model (
   input  wire logic             mclk,
   input  wire logic             arst_n,
   input  wire logic             conv_start,
   input  wire logic [1:0]       conv_chan,
   input  wire logic [9:0]       sup,
   input  wire logic [9:0]       onc,
   input  wire logic [9:0]       rem,
   input  wire logic [3:0]       lat,
   output stm_pkg::stm_adc_rsp_s adc_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   logic [1:0] chan;
   logic       tog;
   // A new start drops any pending answer; code lines churn outside the answer cycle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt     <= 4'h0;
         chan    <= 2'h0;
         tog     <= 1'b0;
         adc_rsp <= '0;
      end else begin
         adc_rsp.done <= 1'b0;
         adc_rsp.code <= ~adc_rsp.code;
         if (conv_start) begin
            cnt  <= lat;
            chan <= conv_chan;
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
               adc_rsp.done <= 1'b1;
               tog          <= ~tog;
               adc_rsp.code <= (chan == stm_pkg::CH_SUPPLY) ? sup :
                               (chan == stm_pkg::CH_ONCHIP) ? onc :
                               rem + (tog ? 10'h002 : 10'h000);
            end
         end
      end
   end
endmodule

// ### sim/stm_sequencer_tb.sv
module stm_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int         LIMIT = 5000;
   localparam logic [7:0] RA [9] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28,
                                     8'h18, 8'h19, 8'h05};
   localparam logic [7:0] RV [9] = '{8'hc7, 8'h62, 8'h64, 8'hc9, 8'h64, 8'hc9,
                                     8'h00, 8'h00, 8'h00};
   logic                  mclk = 1'b0;
   logic                  arst_n;
   stm_pkg::stm_reg_req_s reg_req;
   logic [7:0]            reg_rdata;
   stm_pkg::stm_adc_rsp_s adc_rsp;
   logic                  conv_start;
   logic [1:0]            conv_chan;
   logic                  ref_amp_on;
   logic                  alert;
   logic [9:0]            sup = 10'h2dd;
   logic [9:0]            onc = 10'h366;
   logic [9:0]            rem = 10'h1a0;
   logic [3:0]            lat = 4'h4;
   logic [7:0]            d;
   logic [1:0]            ch;
   int                    n;
   int                    errors;
   int                    checked;
   int                    cycles;
   always #4 mclk = ~mclk;
   stm_sequencer i_stm_sequencer (.mclk(mclk), .arst_n(arst_n), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .adc_rsp(adc_rsp), .conv_start(conv_start),
      .conv_chan(conv_chan), .ref_amp_on(ref_amp_on), .alert(alert));
   stm_adc_model i_stm_adc_model (.mclk(mclk), .arst_n(arst_n), .conv_start(conv_start),
      .conv_chan(conv_chan), .sup(sup), .onc(onc), .rem(rem), .lat(lat), .adc_rsp(adc_rsp));
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge mclk);
      reg_req.wr = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = v;
      @(negedge mclk);
      reg_req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge mclk);
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      @(negedge mclk);
      reg_req.rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic next_start();
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (conv_start !== 1'b1 && n < 200);
      ch = conv_chan;
      check(8'(conv_start), 8'h01);
   endtask
   task automatic count_starts(input int cyc);
      n = 0;
      repeat (cyc) begin
         @(negedge mclk);
         if (conv_start !== 1'b0) n++;
      end
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      for (int i = 0; i < 9; i++) begin
         rd(RA[i]);
         check(d, RV[i]);
      end
      check(8'(alert), 8'h01);
      check(8'(ref_amp_on), 8'h00);
      count_starts(30);
      check(8'(n), 8'h00);
   endtask
   task automatic t_round_robin();
      wr(8'h1f, 8'h08);
      wr(8'h19, 8'h20);
      wr(8'h18, 8'h01);
      check(8'(ref_amp_on), 8'h01);
      for (int i = 0; i < 6; i++) begin
         next_start();
         check(8'(ch), 8'(i % 3));
      end
      rd(8'h03);
      check(d, 8'h09);
      rd(8'h06);
      check(d, 8'hb7);
      rd(8'h07);
      check(d, 8'hdb);
      rd(8'h08);
      check(d, 8'h68);
      check(8'(alert), 8'h00);
      rd(8'h00);
      check(d, 8'h04);
   endtask
   // Views must hold the old supply result until one high-bits read releases them
   task automatic t_lock();
      rd(8'h03);
      sup = 10'h1b7;
      repeat (4) next_start();
      rd(8'h06);
      check(d, 8'hb7);
      repeat (4) next_start();
      rd(8'h06);
      check(d, 8'h6d);
   endtask
   task automatic t_txn();
      @(negedge mclk);
      reg_req.txn_active = 1'b1;
      repeat (2) @(negedge mclk);
      count_starts(20);
      check(8'(n), 8'h00);
      reg_req.txn_active = 1'b0;
      next_start();
      check(8'(n <= 3), 8'h01);
   endtask
   task automatic t_single();
      lat = 4'h1;
      for (int s = 0; s < 3; s++) begin
         wr(8'h19, 8'h30 | 8'(s));
         next_start();
         repeat (3) begin
            next_start();
            check(8'(ch), 8'(s));
            check(8'(n <= 5), 8'h01);
         end
      end
   endtask
   task automatic t_average();
      lat = 4'h2;
      wr(8'h19, 8'h12);
      repeat (40) next_start();
      rd(8'h04);
      check(d, 8'h01);
      rd(8'h08);
      check(d, 8'h68);
      // Single remote samples are even codes; only an average comes out odd
      wr(8'h19, 8'h32);
      repeat (3) next_start();
      rd(8'h04);
      check(8'(d[0]), 8'h00);
   endtask
   task automatic t_alert();
      rem = 10'h000;
      sup = 10'h3ff;
      wr(8'h18, 8'h00);
      wr(8'h19, 8'h20);
      wr(8'h1d, 8'h0f);
      wr(8'h18, 8'h41);
      repeat (4) next_start();
      check(8'(alert), 8'h01);
      rd(8'h06);
      check(d, 8'hff);
      rd(8'h10);
      check(d, 8'h01);
      wr(8'h1e, 8'h01);
      repeat (2) @(negedge mclk);
      check(8'(alert), 8'h00);
      // Once masked, further supply misses must not raise the flag again
      rd(8'h10);
      repeat (4) next_start();
      rd(8'h10);
      check(d, 8'h00);
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      arst_n = 1'b0;
      reg_req = '0;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      arst_n = 1'b1;
      t_reset();
      t_round_robin();
      t_lock();
      t_txn();
      t_single();
      t_average();
      t_alert();
      tally_and_finish();
   end
endmodule
bind stm_sequencer stm_sequencer_assertions i_stm_sequencer_assertions (.mclk(mclk),
   .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .adc_rsp(adc_rsp),
   .conv_start(conv_start), .conv_chan(conv_chan), .ref_amp_on(ref_amp_on), .alert(alert));
